// *** dms_pkg.sv ***
package dms_pkg;

  // =========================================================================
  // register map (byte addresses)
  // =========================================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LAT    = 8'h08;
  localparam logic [7:0] OFS_LOCK   = 8'h0c;
  localparam logic [7:0] OFS_RDREF  = 8'h10;

  // =========================================================================
  // mode register numbers and bit positions
  // =========================================================================
  localparam logic [2:0] MR0_SEL        = 3'h0;
  localparam logic [2:0] MR1_SEL        = 3'h1;
  localparam logic [2:0] MR2_SEL        = 3'h2;
  localparam logic [2:0] MR4_SEL        = 3'h4;
  localparam int         MR1_DLL_EN_BIT = 0;
  localparam int         MR0_DLL_RST_BIT = 8;
  localparam int         MR4_SR_ABORT_BIT = 9;
  localparam int         MR5_PAR_BIT    = 0;

  // =========================================================================
  // reset values and counts
  // =========================================================================
  localparam logic [4:0]  DLL_OFF_CL     = 5'h0a;
  localparam logic [4:0]  DLL_OFF_CWL    = 5'h09;
  localparam logic [10:0] LOCK_MIN_NCK   = 11'h255;
  localparam logic [10:0] LOCK_MAX_NCK   = 11'h400;
  localparam logic [10:0] LOCK_RST_NCK   = 11'h400;
  localparam logic [4:0]  CL_RST         = 5'h0a;
  localparam logic [4:0]  CWL_RST        = 5'h09;
  localparam logic [4:0]  AL_RST         = 5'h00;

  typedef enum logic [3:0] {
    DMS_ON    = 4'b0001,
    DMS_OFF   = 4'b0010,
    DMS_SREF  = 4'b0100,
    DMS_LOCK  = 4'b1000
  } dms_state_t;

endpackage

// *** dms_lock_timer.sv ***
`timescale 1ns/1ps
module dms_lock_timer
  import dms_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // control
  input  wire logic        start,
  input  wire logic        ck_tick,
  input  wire logic [10:0] lock_nck,
  // status
  output logic             busy
);
  logic [10:0] count;

  // =========================================================================
  // lock counter in link clocks
  // =========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= 11'h000;
      busy  <= 1'b0;
    end else if (start) begin
      count <= lock_nck;
      busy  <= 1'b1;
    end else if (busy && ck_tick) begin
      count <= count - 11'h001;
      if (count <= 11'h001) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// *** dms_refresh_ctr.sv ***
`timescale 1ns/1ps
module dms_refresh_ctr
  import dms_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // refresh events
  input  wire logic        refresh_done,
  input  wire logic        sr_exit,
  input  wire logic        abort_en,
  // state
  output logic             refresh_busy,
  output logic [15:0]      refresh_count
);
  // =========================================================================
  // self refresh internal refresh with abort
  // =========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refresh_busy  <= 1'b0;
      refresh_count <= 16'h0000;
    end else if (sr_exit && abort_en) begin
      refresh_busy <= 1'b0;
    end else if (sr_exit) begin
      refresh_busy <= 1'b0;
      if (refresh_busy) begin
        refresh_count <= refresh_count + 16'h0001;
      end
    end else if (refresh_done) begin
      refresh_busy  <= 1'b1;
      refresh_count <= refresh_count + 16'h0001;
    end
  end
endmodule

// *** dms_sequencer.sv ***
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dms_sequencer
  import dms_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // memory-side events
  input  wire logic        ck_tick,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic        mrs_valid,
  input  wire logic [2:0]  mrs_sel,
  input  wire logic [13:0] mrs_op,
  input  wire logic        sr_enter,
  input  wire logic        sr_exit,
  input  wire logic        read_cmd,
  input  wire logic        refresh_done,
  // device outputs
  output logic             dll_enabled,
  output logic             dll_locked,
  output logic             clock_ignored,
  output logic             rtt_nom_active,
  output logic [5:0]       strobe_ref_cyc,
  output logic             read_strobe
);
  import dms_pkg::*;

  // =========================================================================
  // state
  // =========================================================================
  dms_state_t  state;
  logic [4:0]  cl;
  logic [4:0]  cwl;
  logic [4:0]  al;
  logic        sr_abort_en;
  logic        parity_en;
  logic        rtt_nom_en;
  logic        ppd;
  logic [10:0] lock_nck;
  logic        lock_start;
  logic        lock_busy;
  logic        refresh_busy;
  logic [15:0] refresh_count;
  logic [5:0]  rd_cnt;
  logic        rd_run;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        sw_dll_rst;

  function automatic logic mrs_hit(input logic [2:0] sel, input logic [2:0] want);
    return mrs_valid && (sel == want);
  endfunction

  // =========================================================================
  // DLL enable and mode bits
  // =========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dll_enabled <= 1'b1;
      sr_abort_en <= 1'b0;
      parity_en   <= 1'b0;
      rtt_nom_en  <= 1'b0;
    end else if (mrs_hit(mrs_sel, MR1_SEL)) begin
      dll_enabled <= mrs_op[MR1_DLL_EN_BIT];
      rtt_nom_en  <= |mrs_op[10:8];
    end else if (mrs_hit(mrs_sel, MR4_SEL)) begin
      sr_abort_en <= mrs_op[MR4_SR_ABORT_BIT];
    end else if (mrs_hit(mrs_sel, 3'h5)) begin
      parity_en <= mrs_op[MR5_PAR_BIT] && dll_enabled;
    end
  end

  // =========================================================================
  // latencies; DLL-off holds the single pair
  // =========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cl  <= CL_RST;
      cwl <= CWL_RST;
      al  <= AL_RST;
    end else if (!dll_enabled) begin
      cl  <= DLL_OFF_CL;
      cwl <= DLL_OFF_CWL;
    end else if (mrs_hit(mrs_sel, MR0_SEL)) begin
      cl <= mrs_op[6:2];
    end else if (mrs_hit(mrs_sel, MR2_SEL)) begin
      cwl <= mrs_op[7:3];
    end else if (mrs_hit(mrs_sel, MR1_SEL)) begin
      al <= {3'h0, mrs_op[4:3]};
    end
  end

  // =========================================================================
  // power state
  // =========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= DMS_ON;
      ppd   <= 1'b0;
    end else begin
      ppd <= !cke && (state != DMS_SREF);
      case (state)
        DMS_ON: begin
          if (sr_enter) begin
            state <= DMS_SREF;
          end else if (!dll_enabled) begin
            state <= DMS_OFF;
          end
        end
        DMS_OFF: begin
          if (sr_enter) begin
            state <= DMS_SREF;
          end else if (lock_start) begin
            state <= DMS_LOCK;
          end
        end
        DMS_SREF: begin
          if (sr_exit) begin
            state <= dll_enabled ? DMS_ON : DMS_OFF;
          end
        end
        DMS_LOCK: begin
          if (sr_enter) begin
            state <= DMS_SREF;
          end else if (!lock_busy && !lock_start) begin
            state <= DMS_ON;
          end
        end
        default: state <= DMS_ON;
      endcase
    end
  end

  assign clock_ignored  = (state == DMS_SREF);
  assign rtt_nom_active = rtt_nom_en && odt && cke && !clock_ignored && !lock_busy;
  assign dll_locked     = dll_enabled && !lock_busy && (state != DMS_SREF);

  assign lock_start = dll_enabled && (sw_dll_rst ||
                      (mrs_hit(mrs_sel, MR0_SEL) && mrs_op[MR0_DLL_RST_BIT]));

  dms_lock_timer u_lock (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .start    (lock_start),
    .ck_tick  (ck_tick),
    .lock_nck (lock_nck),
    .busy     (lock_busy)
  );

  dms_refresh_ctr u_ref (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .refresh_done  (refresh_done && clock_ignored),
    .sr_exit       (sr_exit),
    .abort_en      (sr_abort_en),
    .refresh_busy  (refresh_busy),
    .refresh_count (refresh_count)
  );

  // =========================================================================
  // read strobe reference
  // =========================================================================
  always_comb begin
    if (dll_enabled) begin
      strobe_ref_cyc = {1'b0, al} + {1'b0, cl};
    end else begin
      strobe_ref_cyc = {1'b0, al} + {1'b0, cl} - 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_cnt      <= 6'h00;
      rd_run      <= 1'b0;
      read_strobe <= 1'b0;
    end else begin
      read_strobe <= 1'b0;
      if (read_cmd) begin
        rd_cnt <= strobe_ref_cyc;
        rd_run <= 1'b1;
      end else if (rd_run && ck_tick) begin
        rd_cnt <= rd_cnt - 6'h01;
        if (rd_cnt <= 6'h01) begin
          rd_run      <= 1'b0;
          read_strobe <= 1'b1;
        end
      end
    end
  end

  // =========================================================================
  // axi4-lite write
  // =========================================================================
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      lock_nck     <= LOCK_RST_NCK;
      sw_dll_rst   <= 1'b0;
    end else begin
      sw_dll_rst <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == OFS_LOCK && w_strb[0] && w_strb[1]) begin
          if (w_data[10:0] < LOCK_MIN_NCK) begin
            lock_nck <= LOCK_MIN_NCK;
          end else if (w_data[10:0] > LOCK_MAX_NCK) begin
            lock_nck <= LOCK_MAX_NCK;
          end else begin
            lock_nck <= w_data[10:0];
          end
        end
        if (aw_addr == OFS_CTRL && w_strb[0]) begin
          sw_dll_rst <= w_data[0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // =========================================================================
  // axi4-lite read
  // =========================================================================
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        OFS_CTRL:   s_axi_rdata <= 32'h0000_0000;
        OFS_STATUS: s_axi_rdata <= {24'h0, refresh_busy, parity_en, sr_abort_en,
                                    ppd, state};
        OFS_LAT:    s_axi_rdata <= {17'h0, al, cwl, cl};
        OFS_LOCK:   s_axi_rdata <= {21'h0, lock_nck};
        OFS_RDREF:  s_axi_rdata <= {refresh_count, 10'h0, strobe_ref_cyc};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** dms_props.sv ***
`timescale 1ns/1ps
module dms_props
  import dms_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // memory side
  input wire logic        mrs_valid,
  input wire logic [2:0]  mrs_sel,
  input wire logic [13:0] mrs_op,
  input wire logic        sr_enter,
  input wire logic        sr_exit,
  input wire logic        dll_enabled,
  input wire logic        dll_locked,
  input wire logic        clock_ignored,
  input wire logic        cke,
  input wire logic        odt,
  input wire logic        rtt_nom_active
);
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic m1;
  logic m0;
  assign m1 = mrs_valid && mrs_sel == MR1_SEL;
  assign m0 = mrs_valid && mrs_sel == MR0_SEL;
  a_dll_off: assert property (m1 && !mrs_op[0] |=> !dll_enabled)
    else $error("dll still enabled");
  a_dll_on: assert property (m1 && mrs_op[0] |=> dll_enabled)
    else $error("dll not enabled");
  a_dll_hold: assert property (!m1 |=> $stable(dll_enabled))
    else $error("dll enable moved");
  a_lock_start: assert property (m0 && mrs_op[8] && dll_enabled |=> !dll_locked [*8])
    else $error("lock not started");
  a_sr_ignore: assert property (sr_enter |=> clock_ignored)
    else $error("clock not ignored");
  a_sr_leave: assert property (sr_exit |=> !clock_ignored)
    else $error("clock still ignored");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken during response");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rtt_off: assert property (clock_ignored || !cke || !odt |-> !rtt_nom_active)
    else $error("termination on while off");
  a_rtt_relock: assert property (dll_enabled && !dll_locked |-> !rtt_nom_active)
    else $error("termination on during relock");
endmodule
bind dms_sequencer dms_props u_props (.*);

// *** dms_mc_model.sv ***
`timescale 1ns/1ps
module dms_mc_model (
  // clock
  input  wire logic        clk_sys,
  // commands
  output logic             ck_tick,
  output logic             cke,
  output logic             odt,
  output logic             mrs_valid,
  output logic [2:0]       mrs_sel,
  output logic [13:0]      mrs_op,
  output logic             sr_enter,
  output logic             sr_exit,
  output logic             read_cmd,
  output logic             refresh_done
);
  // ==========
  // memory clock at one fixed rate
  initial begin
    {ck_tick, odt, mrs_valid, sr_enter, sr_exit, read_cmd, refresh_done} = 7'h0;
    cke = 1;
    mrs_sel = 3'h0;
    mrs_op = 14'h0;
  end
  always @(posedge clk_sys) ck_tick <= ~ck_tick;
  task automatic sync;
    do @(posedge clk_sys); while (!ck_tick);
  endtask
  // mode write after spacing
  task automatic mrs(input logic [2:0] s, input logic [13:0] o);
    repeat (8) @(posedge clk_sys);
    sync;
    mrs_valid <= 1;
    mrs_sel <= s;
    mrs_op <= o;
    @(posedge clk_sys);
    mrs_valid <= 0;
    @(posedge clk_sys);
  endtask
  // 0 enter, 1 exit, 2 read, 3 refresh
  task automatic ev(input int k);
    repeat (4) @(posedge clk_sys);
    sync;
    case (k)
      0: sr_enter <= 1;
      1: sr_exit <= 1;
      2: read_cmd <= 1;
      default: refresh_done <= 1;
    endcase
    if (k < 2) cke <= k[0];
    odt <= 0;
    @(posedge clk_sys);
    {sr_enter, sr_exit, read_cmd, refresh_done} <= 4'h0;
    @(posedge clk_sys);
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import dms_pkg::*;
  logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, v, lk;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        ck_tick, cke, odt, mrs_valid, sr_enter, sr_exit, read_cmd, refresh_done;
  logic [2:0]  mrs_sel;
  logic [13:0] mrs_op;
  logic        dll_enabled, dll_locked, clock_ignored, rtt_nom_active, read_strobe;
  logic [5:0]  strobe_ref_cyc;
  logic [4:0]  cl;
  logic [65:0] e;
  logic [65:0] exp_q[$];
  int          num_errors, comparisons, cycles, tick_n, n0;

  dms_sequencer u_dut (.*);
  dms_mc_model u_mc (.*);

  // ==========
  // clock, watchdog, read monitor
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    tick_n <= tick_n + int'(ck_tick);
    if (cycles == 30000) begin
      num_errors++;
      end_sim;
    end
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("rdata", s_axi_rdata & e[63:32], e[31:0]);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[65:64]});
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, m, x});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge clk_sys);
  endtask
  // memory clocks until strobe or lock
  task automatic cnt(input logic lock, input int x);
    n0 = tick_n;
    repeat (4000) begin
      @(posedge clk_sys);
      if (lock ? dll_locked : read_strobe) break;
    end
    chk("nck", tick_n - n0, x);
  endtask
  task automatic end_sim;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========
  // main sequence
  initial begin
    {clk_sys, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    rst = 1;
    seed = 32'h9b072d39;
    {num_errors, comparisons, cycles, tick_n} = 128'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    rd(OFS_STATUS, 32'hf, 32'h1);
    rd(OFS_LAT, 32'h7fff, {17'h0, AL_RST, CWL_RST, CL_RST});
    rd(OFS_LOCK, 32'h7ff, {21'h0, LOCK_RST_NCK});
    rd(8'h40, 32'hffffffff, 32'h0, 2'h2);
    v = $random(seed);
    lk = v[10:0] < LOCK_MIN_NCK ? LOCK_MIN_NCK : v[10:0] > LOCK_MAX_NCK ? LOCK_MAX_NCK : v[10:0];
    wr(OFS_LOCK, v);
    rd(OFS_LOCK, 32'h7ff, lk);
    u_mc.mrs(MR1_SEL, 14'h0);
    chk("dll_en", dll_enabled, 0);
    u_mc.mrs(MR0_SEL, 14'h3c);
    rd(OFS_LAT, 32'h3ff, {22'h0, DLL_OFF_CWL, DLL_OFF_CL});
    rd(OFS_RDREF, 32'h3f, 32'h9);
    chk("strobe_ref", strobe_ref_cyc, 32'h9);
    u_mc.ev(2);
    cnt(0, 9);
    u_mc.mrs(3'h5, 14'h1);
    rd(OFS_STATUS, 32'h4f, 32'h2);
    u_mc.mrs(MR4_SEL, 14'h200);
    u_mc.ev(0);
    chk("clk_ign", clock_ignored, 1);
    u_mc.ev(3);
    rd(OFS_STATUS, 32'haf, 32'ha4);
    rd(OFS_RDREF, 32'hffff0000, 32'h10000);
    u_mc.ev(1);
    chk("clk_ign", clock_ignored, 0);
    rd(OFS_STATUS, 32'haf, 32'h22);
    rd(OFS_RDREF, 32'hffff0000, 32'h10000);
    u_mc.mrs(MR1_SEL, 14'h1);
    chk("dll_en", dll_enabled, 1);
    u_mc.mrs(3'h5, 14'h1);
    rd(OFS_STATUS, 32'h40, 32'h40);
    cl = 5'h9 + v[13:11];
    u_mc.mrs(MR0_SEL, {5'h0, 2'h2, cl, 2'h0});
    chk("locked", dll_locked, 0);
    cnt(1, lk);
    rd(OFS_LAT, 32'h1f, cl);
    rd(OFS_RDREF, 32'h3f, cl);
    u_mc.ev(2);
    cnt(0, cl);
    u_mc.mrs(MR1_SEL, 14'h101);
    u_mc.odt <= 1'b1;
    @(posedge clk_sys);
    chk("rtt", rtt_nom_active, 1);
    wr(OFS_CTRL, 32'h1);
    @(posedge clk_sys);
    chk("locked", dll_locked, 0);
    chk("rtt", rtt_nom_active, 0);
    cnt(1, lk);
    chk("rtt", rtt_nom_active, 1);
    end_sim;
  end
endmodule
